// ==== logic/dtf_core.sv ====
// Purpose: track read, track write (format) and forced interrupt execution
// Assumes: all inputs synchronous to mclk; read bits come pre-separated
// Notes:   write_cell streams clock/data half cells, msb first
// Operation
// - read track between two index edges, interrupt
// - every read byte to data register, resync marks
// - read track: no crc, no side compare
// - write track between two index edges, interrupt
// - request data at once, wait for first byte
// - empty register at index aborts with lost data
// - missing byte written as zero, continue
// - preset crc on f8-fe, and f5 double
// - f7 emits the two crc bytes
// - single density clock patterns per byte value
// - double density f5/f6 write sync bytes
// - forced interrupt accepted anytime, ends busy
// - low command bits select interrupt conditions
// - enabled condition raises interrupt request
// - all-zero conditions terminate without interrupt
// - immediate interrupt clears only after zero command
// - termination waits for current micro-step end
// - read and write track set busy, force while busy keeps other bits
// - data register access clears data request
// - status read clears interrupt request
`timescale 1ns/1ps
module dtf_core
  import dtf_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic [1:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic        double_density_select_n,
  input  wire logic        index_pulse,
  input  wire logic        drive_ready,
  input  wire logic        rd_bit_valid,
  input  wire logic        rd_bit,
  input  wire logic        address_mark,
  output logic             head_load,
  output logic             write_gate,
  output logic             write_cell,
  output logic             data_request,
  output logic             interrupt_request
);
  import dtf_pkg::*;

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  dtf_state_t  state;
  logic        busy;
  logic        lost_data;
  logic        term_pend;
  logic [7:0]  data_hold;
  logic        dr_full;
  logic [7:0]  div_cnt;
  logic        half_tick;
  logic        idx_q;
  logic        rdy_q;
  logic [15:0] wr_shift;
  logic [3:0]  cell_cnt;
  logic [15:0] crc;
  logic        crc_lo_pend;
  logic        prev_bit;
  logic [7:0]  rd_shift;
  logic [2:0]  rd_cnt;
  logic [3:0]  fi_cond;
  logic        imm_hold;
  logic        imm_clear_ok;
  logic        single_dens;
  logic        cmd_wr;
  logic        fi_wr;
  logic        new_cmd;
  logic        stat_rd;
  logic        data_rd;
  logic        data_wr;
  logic        idx_rise;
  logic        rdy_rise;
  logic        rdy_fall;
  logic        seq_free;
  logic        wr_start;
  logic        wr_fetch;
  logic        byte_done;
  logic        cmd_done;
  logic        intr_set;
  logic        intr_clr;
  logic [7:0]  src_byte;
  logic [7:0]  out_byte;
  logic [7:0]  fm_clk;
  logic [15:0] miss_mask;
  logic [15:0] next_pattern;
  logic [15:0] next_crc;
  logic        next_lo_pend;
  logic        is_mark;
  logic [7:0]  status;

  // ---------------------------------------------------------------
  // helper functions
  // ---------------------------------------------------------------
  // fold one byte into the crc, msb first
  function automatic logic [15:0] crc_byte(input logic [15:0] c_in, input logic [7:0] d);
    logic [15:0] c;
    c = c_in;
    for (int i = 7; i >= 0; i--)
    begin
      if (c[15] ^ d[i])
        c = {c[14:0], 1'b0} ^ CRC_POLY;
      else
        c = {c[14:0], 1'b0};
    end
    return c;
  endfunction

  // interleave clock and data bits into sixteen half cells
  function automatic logic [15:0] cells(input logic [7:0] ck, input logic [7:0] d);
    logic [15:0] p;
    p = '0;
    for (int i = 0; i < 8; i++)
    begin
      p[2*i+1] = ck[i];
      p[2*i]   = d[i];
    end
    return p;
  endfunction

  // double density clock: a one only between two zero data bits
  function automatic logic [7:0] mfm_clk(input logic [7:0] d, input logic prev);
    logic [7:0] ck;
    ck[7] = ~d[7] & ~prev;
    for (int i = 0; i < 7; i++)
    begin
      ck[i] = ~d[i] & ~d[i+1];
    end
    return ck;
  endfunction

  // ---------------------------------------------------------------
  // decode of the register port and line events
  // ---------------------------------------------------------------
  assign single_dens = double_density_select_n;
  assign cmd_wr   = reg_wr & (reg_addr == ADDR_CMD_STATUS);
  assign fi_wr    = cmd_wr & (reg_wdata[7:4] == OP_FORCE_INT);
  assign new_cmd  = cmd_wr & ~fi_wr;
  assign stat_rd  = reg_rd & (reg_addr == ADDR_CMD_STATUS);
  assign data_rd  = reg_rd & (reg_addr == ADDR_DATA);
  assign data_wr  = reg_wr & (reg_addr == ADDR_DATA);
  assign idx_rise = index_pulse & ~idx_q;
  assign rdy_rise = drive_ready & ~rdy_q;
  assign rdy_fall = ~drive_ready & rdy_q;
  // sequencer may advance on its own only when no command or stop acts
  assign seq_free = ~cmd_wr & ~(term_pend & half_tick);
  assign wr_start = seq_free & (state == DTF_WAIT_IDX_WR) & idx_rise & dr_full;
  assign wr_fetch = seq_free & (state == DTF_RUN_WR) & ~idx_rise & half_tick
                    & (cell_cnt == LAST_CELL);
  // bytes assembled from the separator; no crc check on this path
  assign byte_done = seq_free & (state == DTF_RUN_RD) & rd_bit_valid & ~address_mark
                     & (rd_cnt == LAST_BIT);
  assign cmd_done = seq_free & idx_rise & ((state == DTF_RUN_RD) | (state == DTF_RUN_WR)
                    | ((state == DTF_WAIT_IDX_WR) & ~dr_full));

  // half cell divider, one enable pulse per half cell
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      div_cnt <= 8'h00;
    else if (div_cnt == 8'h00)
      div_cnt <= single_dens ? 8'(HALF_FM_CYC - 1) : 8'(HALF_MFM_CYC - 1);
    else
      div_cnt <= div_cnt - 8'h01;
  end
  assign half_tick = (div_cnt == 8'h00);

  // previous levels of index and ready for edge detection
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      idx_q <= 1'b0;
      rdy_q <= 1'b0;
    end
    else
    begin
      idx_q <= index_pulse;
      rdy_q <= drive_ready;
    end
  end

  // ---------------------------------------------------------------
  // command sequencer: state, busy, lost data, head and write gate
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      state      <= DTF_IDLE;
      busy       <= 1'b0;
      lost_data  <= 1'b0;
      term_pend  <= 1'b0;
      head_load  <= 1'b0;
      write_gate <= 1'b0;
    end
    else if (new_cmd)
    begin
      busy       <= 1'b1;
      lost_data  <= 1'b0;
      term_pend  <= 1'b0;
      write_gate <= 1'b0;  // never write while waiting for index
      if (reg_wdata[7:4] == OP_READ_TRACK)
      begin
        state     <= DTF_WAIT_IDX_RD;
        head_load <= 1'b1;
      end
      else if (reg_wdata[7:4] == OP_WRITE_TRACK)
      begin
        state     <= DTF_WAIT_IDX_WR;
        head_load <= 1'b1;
      end
      else
      begin
        state <= DTF_IDLE;  // other commands are handled elsewhere
        busy  <= 1'b0;
      end
    end
    else if (fi_wr)
    begin
      if (busy)
        term_pend <= 1'b1;
      else
        lost_data <= 1'b0;  // idle force refreshes status
    end
    else if (term_pend && half_tick)
    begin
      state      <= DTF_IDLE;  // stop at the micro-step boundary
      busy       <= 1'b0;      // other status bits kept
      term_pend  <= 1'b0;
      head_load  <= 1'b0;
      write_gate <= 1'b0;
    end
    else
    begin
      unique case (state)
        DTF_IDLE:
          ;
        DTF_WAIT_IDX_RD:
          if (idx_rise)
            state <= DTF_RUN_RD;
        DTF_RUN_RD:
        begin
          if (byte_done && data_request)
            lost_data <= 1'b1;  // host missed the previous byte
          if (idx_rise)
          begin
            state     <= DTF_IDLE;
            busy      <= 1'b0;
            head_load <= 1'b0;
          end
        end
        DTF_WAIT_IDX_WR:
          if (idx_rise)
          begin
            if (dr_full)
            begin
              state      <= DTF_RUN_WR;
              write_gate <= 1'b1;
            end
            else
            begin
              state     <= DTF_IDLE;
              busy      <= 1'b0;
              lost_data <= 1'b1;
              head_load <= 1'b0;
            end
          end
        DTF_RUN_WR:
        begin
          if (wr_fetch && !dr_full && !crc_lo_pend)
            lost_data <= 1'b1;
          if (idx_rise)
          begin
            state      <= DTF_IDLE;
            busy       <= 1'b0;
            head_load  <= 1'b0;
            write_gate <= 1'b0;
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // byte interpretation for track write
  // ---------------------------------------------------------------
  assign src_byte = dr_full ? data_hold : BYTE_ZERO;
  assign is_mark  = ((src_byte >= BYTE_MARK_LO) && (src_byte <= BYTE_ID_MARK))
                    || (!single_dens && (src_byte == BYTE_SYNC_A));

  always_comb
  begin
    out_byte     = src_byte;
    fm_clk       = CLK_NORMAL;
    miss_mask    = MISS_NONE;
    next_crc     = crc;
    next_lo_pend = 1'b0;
    if (crc_lo_pend)
      out_byte = crc[7:0];  // second crc byte
    else if (src_byte == BYTE_CRC_REQ)
    begin
      out_byte     = crc[15:8];
      next_lo_pend = 1'b1;
    end
    else
    begin
      if (single_dens)
      begin
        if (src_byte == BYTE_INDEX)
          fm_clk = CLK_INDEX;
        else if (src_byte >= BYTE_MARK_LO && src_byte != BYTE_ZERO - 8'h01)
          fm_clk = (src_byte == BYTE_ID_MARK || src_byte <= BYTE_MARK_HI) ? CLK_MARK
                   : CLK_NORMAL;
      end
      else if (src_byte == BYTE_SYNC_A)
      begin
        out_byte  = BYTE_A1;
        miss_mask = MISS_A1;
      end
      else if (src_byte == BYTE_SYNC_C)
      begin
        out_byte  = BYTE_C2;
        miss_mask = MISS_C2;
      end
      next_crc = crc_byte(is_mark ? CRC_PRESET : crc, out_byte);
    end
    if (single_dens)
      next_pattern = cells(fm_clk, out_byte);
    else
      next_pattern = cells(mfm_clk(out_byte, prev_bit), out_byte) & ~miss_mask;
  end

  // serialiser, crc and write cell output
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_shift    <= 16'h0000;
      cell_cnt    <= 4'h0;
      crc         <= CRC_PRESET;
      crc_lo_pend <= 1'b0;
      prev_bit    <= 1'b0;
      write_cell  <= 1'b0;
    end
    else if (wr_start || wr_fetch)
    begin
      if (wr_fetch)
        write_cell <= wr_shift[15];
      wr_shift    <= next_pattern;
      cell_cnt    <= 4'h0;
      crc         <= next_crc;
      crc_lo_pend <= next_lo_pend;
      prev_bit    <= out_byte[0];
    end
    else if (state == DTF_RUN_WR && half_tick)
    begin
      write_cell <= wr_shift[15];
      wr_shift   <= {wr_shift[14:0], 1'b0};
      cell_cnt   <= cell_cnt + 4'h1;
    end
    else if (state != DTF_RUN_WR)
      write_cell <= 1'b0;
  end

  // ---------------------------------------------------------------
  // track read byte assembly
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      rd_shift <= 8'h00;
      rd_cnt   <= 3'h0;
    end
    else if (state != DTF_RUN_RD)
      rd_cnt <= 3'h0;
    else if (address_mark)
      rd_cnt <= 3'h0;  // mark detector armed throughout, realigns bytes
    else if (rd_bit_valid)
    begin
      rd_shift <= {rd_shift[6:0], rd_bit};
      rd_cnt   <= rd_cnt + 3'h1;
    end
  end

  // data holding register and its loaded flag
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      data_hold <= 8'h00;
      dr_full   <= 1'b0;
    end
    else if (byte_done)
      data_hold <= {rd_shift[6:0], rd_bit};
    else if (data_wr)
    begin
      data_hold <= reg_wdata;
      dr_full   <= 1'b1;
    end
    else if (new_cmd || wr_start || (wr_fetch && !crc_lo_pend))
      dr_full <= 1'b0;
  end

  // data request: set by each byte event but the first crc byte, cleared by any data access
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      data_request <= 1'b0;
    else if (byte_done || wr_start || (wr_fetch && !next_lo_pend))
      data_request <= 1'b1;
    else if (new_cmd && reg_wdata[7:4] == OP_WRITE_TRACK)
      data_request <= 1'b1;
    else if (data_rd || data_wr || new_cmd)
      data_request <= 1'b0;
  end

  // ---------------------------------------------------------------
  // interrupt request and forced interrupt conditions
  // ---------------------------------------------------------------
  assign intr_set = cmd_done
                    | (fi_wr & reg_wdata[COND_IMMED])
                    | (fi_cond[COND_NR_TO_R] & rdy_rise)
                    | (fi_cond[COND_R_TO_NR] & rdy_fall)
                    | (fi_cond[COND_INDEX] & idx_rise);
  assign intr_clr = (stat_rd | cmd_wr) & (~imm_hold | (imm_clear_ok & ~fi_wr));

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      fi_cond      <= 4'h0;
      imm_hold     <= 1'b0;
      imm_clear_ok <= 1'b0;
    end
    else if (fi_wr)
    begin
      fi_cond      <= reg_wdata[3:0];
      imm_hold     <= imm_hold | reg_wdata[COND_IMMED];
      imm_clear_ok <= (reg_wdata[3:0] == 4'h0);
    end
    else if (new_cmd || stat_rd)
    begin
      if (new_cmd)
        fi_cond <= 4'h0;
      if (imm_clear_ok)
      begin
        imm_hold     <= 1'b0;
        imm_clear_ok <= 1'b0;
      end
    end
  end

  // a set in the same cycle as a clear wins
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      interrupt_request <= 1'b0;
    else if (intr_set)
      interrupt_request <= 1'b1;
    else if (intr_clr)
      interrupt_request <= 1'b0;
  end

  // ---------------------------------------------------------------
  // read data, one cycle after the strobe
  // ---------------------------------------------------------------
  always_comb
  begin
    status               = 8'h00;
    status[ST_BUSY]      = busy;
    status[ST_DRQ]       = data_request;
    status[ST_LOST]      = lost_data;
    status[ST_NOT_READY] = ~drive_ready;
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      reg_rdata <= 8'h00;
    else if (stat_rd)
      reg_rdata <= status;
    else if (data_rd)
      reg_rdata <= data_hold;
    else
      reg_rdata <= 8'h00;
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  localparam int TERM_MAX = 260;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  sequence s_rd_end;
    (state == DTF_RUN_RD) && idx_rise && seq_free;
  endsequence

  sequence s_idle_intr;
    !busy && interrupt_request;
  endsequence

  a_read_track_end: assert property (s_rd_end |=> s_idle_intr)
    else $error("read track did not finish at index");
  a_write_drq_now: assert property (new_cmd && reg_wdata[7:4] == OP_WRITE_TRACK
    |=> data_request && busy && !write_gate)
    else $error("write track did not request data");
  a_abort_no_data: assert property (seq_free && state == DTF_WAIT_IDX_WR && idx_rise
    && !dr_full |=> !busy && lost_data && interrupt_request)
    else $error("unloaded write track did not abort");
  a_zero_fill: assert property (wr_fetch && !dr_full && !crc_lo_pend
    |-> out_byte == BYTE_ZERO ##1 lost_data)
    else $error("missing byte not replaced by zero");
  a_crc_preset: assert property ((wr_start || wr_fetch) && !crc_lo_pend && src_byte >= BYTE_MARK_LO
    && src_byte <= BYTE_ID_MARK |=> crc == crc_byte(CRC_PRESET, $past(out_byte)))
    else $error("crc not preset on mark byte");
  a_force_ends_busy: assert property (fi_wr && busy
    |-> ##[1:TERM_MAX] !busy)
    else $error("forced interrupt did not end command");
  a_zero_force_quiet: assert property (fi_wr && reg_wdata[3:0] == 4'h0
    && !interrupt_request |=> !interrupt_request)
    else $error("all-zero force raised interrupt");
  a_immediate_held: assert property (imm_hold && !imm_clear_ok && (stat_rd || new_cmd)
    |=> interrupt_request)
    else $error("immediate interrupt cleared early");
  a_data_access_drq: assert property ((data_rd || data_wr) && state == DTF_IDLE
    && !cmd_wr |=> !data_request)
    else $error("data access left data request set");
  a_status_clears: assert property (stat_rd && !imm_hold && !intr_set
    |=> !interrupt_request)
    else $error("status read kept interrupt request");

endmodule

// ==== pkg/dtf_pkg.sv ====
// Purpose: shared constants and types for the disk track command block
// Assumes: 125 MHz mclk, bit cells timed as a device running at 2 MHz
// Notes:   register indices, byte patterns, clock patterns and cell timing
package dtf_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 8;
  localparam int HALF_CELL_FM_NS  = 2000;  // half of a single density bit cell
  localparam int HALF_CELL_MFM_NS = 1000;  // half of a double density bit cell
  localparam int HALF_FM_CYC  = (HALF_CELL_FM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HALF_MFM_CYC = (HALF_CELL_MFM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // register port
  // ---------------------------------------------------------------
  localparam logic [1:0] ADDR_CMD_STATUS = 2'h0;  // write command, read status
  localparam logic [1:0] ADDR_DATA       = 2'h3;  // data holding register

  localparam logic [3:0] OP_READ_TRACK  = 4'he;
  localparam logic [3:0] OP_WRITE_TRACK = 4'hf;
  localparam logic [3:0] OP_FORCE_INT   = 4'hd;

  localparam int ST_BUSY      = 0;
  localparam int ST_DRQ       = 1;
  localparam int ST_LOST      = 2;
  localparam int ST_NOT_READY = 7;

  // forced interrupt condition bit positions
  localparam int COND_NR_TO_R  = 0;
  localparam int COND_R_TO_NR  = 1;
  localparam int COND_INDEX    = 2;
  localparam int COND_IMMED    = 3;

  // ---------------------------------------------------------------
  // track byte patterns
  // ---------------------------------------------------------------
  localparam logic [7:0] BYTE_ZERO    = 8'h00;
  localparam logic [7:0] BYTE_SYNC_A  = 8'hf5;  // writes a1 in double density
  localparam logic [7:0] BYTE_SYNC_C  = 8'hf6;  // writes c2 in double density
  localparam logic [7:0] BYTE_CRC_REQ = 8'hf7;
  localparam logic [7:0] BYTE_MARK_LO = 8'hf8;
  localparam logic [7:0] BYTE_MARK_HI = 8'hfb;
  localparam logic [7:0] BYTE_INDEX   = 8'hfc;
  localparam logic [7:0] BYTE_ID_MARK = 8'hfe;
  localparam logic [7:0] BYTE_A1      = 8'ha1;
  localparam logic [7:0] BYTE_C2      = 8'hc2;
  localparam logic [7:0] CLK_NORMAL   = 8'hff;
  localparam logic [7:0] CLK_MARK     = 8'hc7;
  localparam logic [7:0] CLK_INDEX    = 8'hd7;

  // cell positions of the clock bits dropped in double density sync bytes
  localparam logic [15:0] MISS_A1 = 16'h0020;  // clock before data bit 2
  localparam logic [15:0] MISS_C2 = 16'h0080;  // clock before data bit 3
  localparam logic [15:0] MISS_NONE = 16'h0000;

  localparam logic [15:0] CRC_PRESET = 16'hffff;
  localparam logic [15:0] CRC_POLY   = 16'h1021;
  localparam logic [3:0]  LAST_CELL  = 4'hf;
  localparam logic [2:0]  LAST_BIT   = 3'h7;

  typedef enum logic [2:0] {
    DTF_IDLE,
    DTF_WAIT_IDX_RD,
    DTF_RUN_RD,
    DTF_WAIT_IDX_WR,
    DTF_RUN_WR
  } dtf_state_t;

endpackage

// ==== sim/dtf_drive_model.sv ====
// Purpose: drive model: index pulse, ready level, separated read bits
// Assumes: tasks are called from the bench just after a clock edge
// Notes:   rd_bit shows the inverse of its last value between strobes
`timescale 1ns/1ps
module dtf_drive_model
(
  input  wire logic mclk,
  output logic      index_pulse,
  output logic      drive_ready,
  output logic      rd_bit_valid,
  output logic      rd_bit,
  output logic      address_mark
);
  // idle drive, ready, no bits
  initial
  begin
    index_pulse  = 1'b0;
    drive_ready  = 1'b1;
    rd_bit_valid = 1'b0;
    rd_bit       = 1'b0;
    address_mark = 1'b0;
  end
  // one index pulse, 16 cycles wide
  task automatic index();
    @(posedge mclk) index_pulse <= 1'b1;
    repeat (16) @(posedge mclk);
    index_pulse <= 1'b0;
  endtask
  // n bits msb first, line turned over once the strobe is gone
  task automatic send(input logic [7:0] b, input int n);
    for (int i = 7; i > 7 - n; i--)
    begin
      @(posedge mclk);
      rd_bit_valid <= 1'b1;
      rd_bit       <= b[i];
      @(posedge mclk);
      rd_bit_valid <= 1'b0;
      rd_bit       <= ~b[i];
      repeat (2) @(posedge mclk);
    end
  endtask
  // one-cycle mark detector pulse
  task automatic mark();
    @(posedge mclk) address_mark <= 1'b1;
    @(posedge mclk) address_mark <= 1'b0;
  endtask
  task automatic set_ready(input logic v);
    @(posedge mclk) drive_ready <= v;
  endtask
endmodule

// ==== sim/test_disk_track_rw_and_forced_interrupt.sv ====
// Purpose: self-checking bench for track read, track write and forced interrupt
// Assumes: single density throughout, 8 ns mclk
// Notes:   flags are waited on under a bound, status is masked per check
`timescale 1ns/1ps
module test_disk_track_rw_and_forced_interrupt;
  import dtf_pkg::*;
  logic       mclk, nrst, reg_wr, reg_rd, dd_n;
  logic [1:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic       index_pulse, drive_ready, rd_bit_valid, rd_bit, address_mark;
  logic       head_load, write_gate, write_cell, data_request, interrupt_request;
  logic [3:0] outs;
  int         errors, n_checks;
  logic [7:0] cmds [4] = '{8'hd2, 8'hd1, 8'hd4, 8'hd6};
  // flags watched by the wait task
  assign outs = {interrupt_request, write_gate, head_load, data_request};
  always #4 mclk = ~mclk;
  dtf_drive_model drv (.mclk(mclk), .index_pulse(index_pulse), .drive_ready(drive_ready),
    .rd_bit_valid(rd_bit_valid), .rd_bit(rd_bit), .address_mark(address_mark));
  dtf_core dut (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .double_density_select_n(dd_n), .index_pulse(index_pulse), .drive_ready(drive_ready),
    .rd_bit_valid(rd_bit_valid), .rd_bit(rd_bit), .address_mark(address_mark),
    .head_load(head_load), .write_gate(write_gate), .write_cell(write_cell),
    .data_request(data_request), .interrupt_request(interrupt_request));
  task automatic finish_test();
    if (errors == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // read a register and compare the masked value
  task automatic rc(input logic [1:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    n_checks++;
    if ((reg_rdata & m) !== e)
    begin
      errors++;
      $display("mismatch at %0t: read %h expected %h", $time, reg_rdata & m, e);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    #1;
  endtask
  // bounded wait for one output flag to reach a level
  task automatic wt(input int k, input logic v, input int n);
    int i;
    i = 0;
    #1;
    while (i < n && outs[k] !== v)
    begin
      @(posedge mclk);
      #1;
      i++;
    end
    n_checks++;
    if (outs[k] !== v)
    begin
      errors++;
      $display("mismatch at %0t: flag %0d never reached %b", $time, k, v);
      finish_test();
    end
  endtask
  // single density write cells at mid half cell, phased on the first fall
  task automatic cells_chk(input logic [27:0] e);
    int   i;
    logic up;
    i  = 0;
    up = 1'b0;
    while (i < 1600 && !(up && write_cell === 1'b0))
    begin
      up = up | (write_cell === 1'b1);
      @(posedge mclk);
      #1;
      i++;
    end
    if (!(up && write_cell === 1'b0))
    begin
      errors++;
      $display("mismatch at %0t: write cell never toggled", $time);
      finish_test();
    end
    repeat (HALF_FM_CYC / 2) @(posedge mclk);
    for (int k = 27; k >= 0; k--)
    begin
      #1;
      n_checks++;
      if (write_cell !== e[k])
      begin
        errors++;
        $display("mismatch at %0t: write cell %0d is %b", $time, k, write_cell);
      end
      repeat (HALF_FM_CYC) @(posedge mclk);
    end
  endtask
  // host pause after a command write
  task automatic settle();
    repeat (3500) @(posedge mclk);
  endtask
  // main sequence
  initial
  begin
    mclk = 1'b0; nrst = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; dd_n = 1'b1;
    reg_addr = 2'h0; reg_wdata = 8'h00; errors = 0; n_checks = 0;
    repeat (12) @(posedge mclk);
    nrst <= 1'b1;
    rc(ADDR_CMD_STATUS, 8'hff, 8'h00);
    rc(2'h1, 8'hff, 8'h00);
    wr(ADDR_CMD_STATUS, 8'h00);
    rc(ADDR_CMD_STATUS, 8'h01, 8'h00);
    wr(ADDR_CMD_STATUS, 8'he0);
    settle();
    rc(ADDR_CMD_STATUS, 8'h01, 8'h01);
    drv.index();
    drv.send(8'h4e, 8);
    wt(0, 1'b1, 20);
    rc(ADDR_DATA, 8'hff, 8'h4e);
    wt(0, 1'b0, 2);
    drv.send(8'hff, 3);
    drv.mark();
    drv.send(8'ha1, 8);
    wt(0, 1'b1, 20);
    rc(ADDR_DATA, 8'hff, 8'ha1);
    drv.index();
    wt(3, 1'b1, 20);
    rc(ADDR_CMD_STATUS, 8'h05, 8'h00);
    wt(3, 1'b0, 1);
    wr(ADDR_CMD_STATUS, 8'hf0);
    wt(0, 1'b1, 3);
    settle();
    wr(ADDR_DATA, 8'hfe);
    wt(0, 1'b0, 3);
    drv.index();
    wt(2, 1'b1, 20);
    wt(0, 1'b1, 300);
    cells_chk({12'h57e, 16'haaaa});
    rc(ADDR_CMD_STATUS, 8'h05, 8'h05);
    wt(2, 1'b1, 1);
    wr(ADDR_CMD_STATUS, 8'hd8);
    wt(2, 1'b0, 300);
    wt(3, 1'b1, 3);
    rc(ADDR_CMD_STATUS, 8'h05, 8'h04);
    wt(3, 1'b1, 1);
    wr(ADDR_CMD_STATUS, 8'hd0);
    settle();
    rc(ADDR_CMD_STATUS, 8'h05, 8'h00);
    wt(3, 1'b0, 2);
    wr(ADDR_CMD_STATUS, 8'hf0);
    settle();
    drv.index();
    wt(3, 1'b1, 20);
    rc(ADDR_CMD_STATUS, 8'h05, 8'h04);
    wr(ADDR_CMD_STATUS, 8'he0);
    settle();
    drv.index();
    wr(ADDR_CMD_STATUS, 8'hd0);
    wt(1, 1'b0, 300);
    wt(3, 1'b0, 1);
    rc(ADDR_CMD_STATUS, 8'h01, 8'h00);
    settle();
    for (int i = 0; i < 4; i++)
    begin
      wr(ADDR_CMD_STATUS, cmds[i]);
      settle();
      wt(3, 1'b0, 1);
      if (i == 0)
        drv.set_ready(1'b0);
      else if (i == 1)
        drv.set_ready(1'b1);
      else
        drv.index();
      wt(3, 1'b1, 40);
      rc(ADDR_CMD_STATUS, 8'h80, (i == 0) ? 8'h80 : 8'h00);
      wt(3, 1'b0, 1);
      wr(ADDR_CMD_STATUS, 8'hd0);
      settle();
    end
    finish_test();
  end
endmodule
